/* File: matrix_bus_pkg.sv */
// Shared constants for the three-wire matrix control link.
// Assumes a 20 MHz system clock on the host end.
package matrix_bus_pkg;

   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int WORD_LEN  = 8;          // Clock pulses per word
   localparam int SUB_W     = 5;          // Upper subaddress field
   localparam int SEL_W     = 3;          // Lower input select field
   localparam int N_OUT     = 6;          // Selectable outputs
   localparam int N_IN      = 8;          // Selectable inputs
   localparam int OUT_IDX_W = 3;          // Width of an output index
   localparam int REPLY_LEN = 8;          // Reply bits per addressing

   // Subaddress code of each output, in output index order
   localparam logic [SUB_W-1:0] OUT0_CODE = 5'h00;
   localparam logic [SUB_W-1:0] OUT1_CODE = 5'h04;
   localparam logic [SUB_W-1:0] OUT2_CODE = 5'h02;
   localparam logic [SUB_W-1:0] OUT3_CODE = 5'h01;
   localparam logic [SUB_W-1:0] OUT4_CODE = 5'h05;
   localparam logic [SUB_W-1:0] OUT5_CODE = 5'h03;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SYS_PERIOD_NS = 50;     // 20 MHz
   localparam int MIN_PHASE_NS  = 1000;   // Shortest phase or spacing
   localparam int LONG_PHASE_NS = 2000;   // Longer specified intervals
   localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int LONG_PHASE_CYC = (LONG_PHASE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   // Half period of the link clock, so a full period covers the long interval
   localparam int LINK_HALF_CYC = (2 * MIN_PHASE_CYC >= LONG_PHASE_CYC) ?
                                  MIN_PHASE_CYC : (LONG_PHASE_CYC + 1) / 2;
   localparam int SYNC_LAT   = 3;         // Link clocks from enable rise to first reply bit
   localparam int TAIL_FALLS = SYNC_LAT + REPLY_LEN + 1;   // Enable-high falls per word

   // Host sequencer states
   typedef enum logic [1:0] {
      M_IDLE,
      M_SHIFT,
      M_TAIL
   } host_state_e;

endpackage : matrix_bus_pkg

/* File: matrix_link_if.sv */
// Three-wire link between the host and the matrix switch.
// Assumes an external pull-up: the data line reads high when nobody drives.
`timescale 1ns/10ps
interface matrix_link_if;
   logic lclk;      // Link clock, host driven
   logic ena;       // Enable, host driven, low during a word
   logic m_dout;    // Host data out
   logic m_oe_n;    // Host data enable, low drives
   logic d_dout;    // Device data out
   logic d_oe_n;    // Device data enable, low drives
   logic data;      // Resolved data line

   // Resolve the shared data line
   assign data = !m_oe_n ? m_dout : (!d_oe_n ? d_dout : 1'b1);

   modport host (
      output lclk,
      output ena,
      output m_dout,
      output m_oe_n,
      input  data
   );

   modport dev (
      input  lclk,
      input  ena,
      input  data,
      output d_dout,
      output d_oe_n
   );
endinterface : matrix_link_if

/* File: sync2.sv */
// Two-stage synchroniser for levels entering a clock domain.
// Assumes each bit is an independent level.
`timescale 1ns/10ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } sync_s;

   sync_s s_r;
   sync_s s_nxt;

   // First stage feeds only the second
   always_comb begin
      s_nxt.ff1 = d;
      s_nxt.ff2 = s_r.ff1;
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign q = s_r.ff2;

endmodule : sync2

/* File: switch_host.sv */
// Host end of the three-wire link: makes the link clock, sends words,
// clocks back the chosen number of reply bits, at most eight.
// Assumes the user spaces requests by waiting for done.
`timescale 1ns/10ps
module switch_host
   import matrix_bus_pkg::*;
#(
   parameter int HALF_CYC = LINK_HALF_CYC
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   matrix_link_if.host               bus,
   input  wire logic                 req,
   input  wire logic [WORD_LEN-1:0]  wdata,
   input  wire logic [3:0]           rd_bits,
   output logic                      busy,
   output logic                      done,
   output logic      [REPLY_LEN-1:0] rdata
);

   localparam int DIV_W  = $clog2(HALF_CYC + 1);
   localparam int BIT_W  = $clog2(WORD_LEN + 1);
   localparam int TAIL_W = $clog2(TAIL_FALLS + 1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [DIV_W-1:0]     div;
      logic                 lclk;
      host_state_e          st;
      logic                 ena;
      logic                 dout;
      logic                 oe_n;
      logic [BIT_W-1:0]     bits;
      logic [WORD_LEN-1:0]  wsh;
      logic [TAIL_W-1:0]    tcnt;
      logic [3:0]           rd_left;
      logic [REPLY_LEN-1:0] rsh;
      logic                 busy;
      logic                 done;
   } host_s;

   host_s s_r;
   host_s s_nxt;
   logic  din_s;
   logic  fall;

   // Data line from the device domain
   sync2 #(.W(1)) u_din_sync (
      .clk (sys_clk),
      .d   (bus.data),
      .q   (din_s)
   );

   assign fall = (s_r.div == DIV_W'(HALF_CYC - 1)) && s_r.lclk;

   // ------------------------------------------------------------
   // Divider and word sequencer
   // ------------------------------------------------------------
   always_comb begin
      logic [TAIL_W-1:0] t;
      t = s_r.tcnt + TAIL_W'(1);
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      // Link clock, each phase at least the minimum
      if (s_r.div == DIV_W'(HALF_CYC - 1)) begin
         s_nxt.div  = '0;
         s_nxt.lclk = ~s_r.lclk;
      end else begin
         s_nxt.div = s_r.div + DIV_W'(1);
      end
      // Take a request while idle
      if (req && !s_r.busy) begin
         s_nxt.busy    = 1'b1;
         s_nxt.wsh     = wdata;
         s_nxt.rd_left = (rd_bits > 4'(REPLY_LEN)) ? 4'(REPLY_LEN) : rd_bits;
         s_nxt.rsh     = '0;
      end
      // Data and enable change only on falling link clock
      if (fall) begin
         case (s_r.st)
            M_IDLE: begin
               if (s_r.busy) begin
                  s_nxt.ena  = 1'b0;
                  s_nxt.oe_n = 1'b0;
                  s_nxt.dout = s_r.wsh[WORD_LEN-1];
                  s_nxt.wsh  = {s_r.wsh[WORD_LEN-2:0], 1'b0};
                  s_nxt.bits = BIT_W'(WORD_LEN - 1);
                  s_nxt.st   = M_SHIFT;
               end
            end
            M_SHIFT: begin
               if (s_r.bits != '0) begin
                  s_nxt.dout = s_r.wsh[WORD_LEN-1];
                  s_nxt.wsh  = {s_r.wsh[WORD_LEN-2:0], 1'b0};
                  s_nxt.bits = s_r.bits - BIT_W'(1);
               end else begin
                  s_nxt.ena  = 1'b1;                    // Word ends
                  s_nxt.oe_n = 1'b1;
                  s_nxt.dout = 1'b0;
                  s_nxt.tcnt = '0;
                  s_nxt.st   = M_TAIL;
               end
            end
            M_TAIL: begin
               // Take only the wanted reply bits
               if (t >= TAIL_W'(SYNC_LAT) && s_r.rd_left != 4'h0) begin
                  s_nxt.rsh     = {s_r.rsh[REPLY_LEN-2:0], din_s};
                  s_nxt.rd_left = s_r.rd_left - 4'h1;
               end
               if (t == TAIL_W'(TAIL_FALLS)) begin
                  s_nxt.st   = M_IDLE;                  // Long gap held
                  s_nxt.busy = 1'b0;
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.tcnt = t;
               end
            end
            default: begin
               s_nxt.st = M_IDLE;
            end
         endcase
      end
      if (rst) begin
         s_nxt      = '0;
         s_nxt.ena  = 1'b1;
         s_nxt.oe_n = 1'b1;
         s_nxt.st   = M_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      s_r <= s_nxt;
   end

   // Outputs straight from state
   assign bus.lclk   = s_r.lclk;
   assign bus.ena    = s_r.ena;
   assign bus.m_dout = s_r.dout;
   assign bus.m_oe_n = s_r.oe_n;
   assign busy       = s_r.busy;
   assign done       = s_r.done;
   assign rdata      = s_r.rsh;

endmodule : switch_host

/* File: switch_dev.sv */
// Device end of the three-wire link: decodes words into the routing of a
// six-output, eight-input matrix and returns one reply word per addressing.
// Assumes the link clock runs free and its reset is synchronous to it.
`timescale 1ns/10ps
module switch_dev
   import matrix_bus_pkg::*;
#(
   parameter int RLEN = REPLY_LEN
) (
   input  wire logic                        rst,
   matrix_link_if.dev                       bus,
   output logic [N_OUT-1:0][SEL_W-1:0]      route_sel,
   output logic [N_OUT-1:0]                 route_set,
   output logic                             word_ok,
   output logic                             word_skip
);

   localparam int CNT_W = $clog2(WORD_LEN + 2);
   localparam int REP_W = $clog2(RLEN + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic                           ena_d;
      logic [CNT_W-1:0]               cnt;
      logic [WORD_LEN-1:0]            shreg;
      logic [N_OUT-1:0][SEL_W-1:0]    route;
      logic [N_OUT-1:0]               set;
      logic [OUT_IDX_W-1:0]           last_idx;
      logic [RLEN-1:0]                rep_sh;
      logic [REP_W-1:0]               rep_left;
      logic                           rep_act;
      logic                           dout;
      logic                           oe_n;
      logic                           ok_p;
      logic                           skip_p;
   } dev_s;

   dev_s s_r;
   dev_s s_nxt;
   logic ena_s;
   logic din_s;

   // ------------------------------------------------------------
   // Subaddress decode
   // ------------------------------------------------------------
   // Returns {hit, output index}; unused codes miss
   function automatic logic [OUT_IDX_W:0] decode_out(input logic [SUB_W-1:0] code);
      case (code)
         OUT0_CODE: return 4'h8;
         OUT1_CODE: return 4'h9;
         OUT2_CODE: return 4'ha;
         OUT3_CODE: return 4'hb;
         OUT4_CODE: return 4'hc;
         OUT5_CODE: return 4'hd;
         default:   return 4'h0;
      endcase
   endfunction : decode_out

   // Subaddress code of an output; not called, the reply word takes the received code
   function automatic logic [SUB_W-1:0] out_code(input logic [OUT_IDX_W-1:0] idx);
      case (idx)
         3'h0:    return OUT0_CODE;
         3'h1:    return OUT1_CODE;
         3'h2:    return OUT2_CODE;
         3'h3:    return OUT3_CODE;
         3'h4:    return OUT4_CODE;
         default: return OUT5_CODE;
      endcase
   endfunction : out_code

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   // Enable and data are host driven, so both pass two flops
   sync2 #(.W(2)) u_in_sync (
      .clk (bus.lclk),
      .d   ({bus.ena, bus.data}),
      .q   ({ena_s, din_s})
   );

   // ------------------------------------------------------------
   // Word receive, decode and reply
   // ------------------------------------------------------------
   always_comb begin
      logic [OUT_IDX_W:0]    hit;
      logic [SUB_W-1:0]      sub;
      logic [SEL_W-1:0]      sel;
      logic [WORD_LEN-1:0]   rep_word;
      logic [RLEN-1:0]       rep_full;
      hit      = '0;
      sub      = s_r.shreg[WORD_LEN-1 -: SUB_W];
      sel      = s_r.shreg[SEL_W-1:0];
      rep_word = '0;
      rep_full = '0;
      s_nxt        = s_r;
      s_nxt.ok_p   = 1'b0;
      s_nxt.skip_p = 1'b0;
      s_nxt.ena_d  = ena_s;
      if (!ena_s) begin
         // Count and shift only while enable is low
         if (s_r.ena_d) begin
            s_nxt.cnt = CNT_W'(1);
         end else if (s_r.cnt != CNT_MAX) begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
         end
         s_nxt.shreg   = {s_r.shreg[WORD_LEN-2:0], din_s};
         // Host owns the line during a word
         s_nxt.rep_act = 1'b0;
         s_nxt.oe_n    = 1'b1;
         s_nxt.dout    = 1'b0;
      end else if (!s_r.ena_d) begin
         // Enable has risen: evaluate the finished word
         hit = decode_out(sub);
         if (s_r.cnt == CNT_W'(WORD_LEN) && hit[OUT_IDX_W]) begin
            // One selection per output, overwriting the old one
            s_nxt.route[hit[OUT_IDX_W-1:0]] = sel;
            s_nxt.set[hit[OUT_IDX_W-1:0]]   = 1'b1;
            s_nxt.last_idx = hit[OUT_IDX_W-1:0];
            s_nxt.ok_p     = 1'b1;
            // Reply is the routing of the output just addressed
            rep_word = {sub, sel};
            // Short reply keeps the top bits, long reply pads low zeros
            rep_full = RLEN'({rep_word, {RLEN{1'b0}}} >> WORD_LEN);
            // First reply bit on the third link clock after the enable rise
            s_nxt.dout     = rep_full[RLEN-1];
            s_nxt.oe_n     = 1'b0;
            s_nxt.rep_sh   = {rep_full[RLEN-2:0], 1'b0};
            s_nxt.rep_left = REP_W'(RLEN - 1);
            s_nxt.rep_act  = 1'b1;
         end else begin
            // Foreign or malformed word: routing kept, line released
            s_nxt.skip_p  = 1'b1;
            s_nxt.rep_act = 1'b0;
            s_nxt.oe_n    = 1'b1;
            s_nxt.dout    = 1'b0;
         end
      end else if (s_r.rep_act) begin
         // One reply bit per clock; host may stop at any bit
         if (s_r.rep_left != '0) begin
            s_nxt.dout     = s_r.rep_sh[RLEN-1];
            s_nxt.rep_sh   = {s_r.rep_sh[RLEN-2:0], 1'b0};
            s_nxt.rep_left = s_r.rep_left - REP_W'(1);
         end else begin
            // Clock after the last bit releases the line
            s_nxt.rep_act = 1'b0;
            s_nxt.oe_n    = 1'b1;
            s_nxt.dout    = 1'b0;
         end
      end
      if (rst) begin
         s_nxt       = '0;
         s_nxt.oe_n  = 1'b1;
         // Idle enable level, so release gives no false rise
         s_nxt.ena_d = 1'b1;
      end
   end

   always_ff @(posedge bus.lclk) begin
      s_r <= s_nxt;
   end

   // Outputs straight from state
   assign bus.d_dout = s_r.dout;
   assign bus.d_oe_n = s_r.oe_n;
   assign route_sel  = s_r.route;
   assign route_set  = s_r.set;
   assign word_ok    = s_r.ok_p;
   assign word_skip  = s_r.skip_p;

endmodule : switch_dev

/* File: matrix_link_sva.sv */
// Checker for the three-wire link between host and matrix switch.
// Assumes the link signals and the device reset as plain inputs.
`timescale 1ns/10ps
module matrix_link_sva (
   input wire logic lclk,
   input wire logic rst,
   input wire logic ena,
   input wire logic m_oe_n,
   input wire logic d_dout,
   input wire logic d_oe_n,
   input wire logic data
);
   default clocking dc @(posedge lclk); endclocking
   default disable iff (rst);

   logic       ena_r;
   logic       doe_r;
   logic [3:0] cnt_r;
   logic [7:0] w_r;
   logic [7:0] rep_r;
   logic [1:0] nrep_r;

   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   // Track word length, word bits, reply bits and replies per phase
   always_ff @(posedge lclk) begin
      ena_r <= ena;
      doe_r <= d_oe_n;
      if (rst) begin
         cnt_r  <= '0;
         w_r    <= '0;
         rep_r  <= '0;
         nrep_r <= '0;
      end else begin
         if (!ena) begin
            cnt_r <= ena_r ? 4'h1 : ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1);
            w_r   <= {w_r[6:0], data};
         end
         if (!d_oe_n) rep_r <= {rep_r[6:0], d_dout};
         if (!ena) nrep_r <= '0;
         else if (doe_r && !d_oe_n && nrep_r != 2'h3) nrep_r <= nrep_r + 2'h1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_no_clash: assert property (!(!m_oe_n && !d_oe_n))
      else $error("both ends drive the data line");
   a_quiet_ena_low: assert property (!ena [*3] |=> d_oe_n)
      else $error("device drives data while enable low");
   a_reply_len: assert property ($fell(d_oe_n) |-> !d_oe_n [*8] ##1 d_oe_n)
      else $error("reply not eight bits then release");
   a_reply_after_ena: assert property ($fell(d_oe_n) |-> ena && $past(ena, 3))
      else $error("reply started without enable high");
   a_reply_echo: assert property ($rose(d_oe_n) |-> rep_r == w_r)
      else $error("reply differs from the addressed routing");
   a_bad_no_reply: assert property ($fell(d_oe_n) |-> cnt_r == 4'h8 && w_r[7:3] < 5'h06)
      else $error("reply to a word not addressed to device");
   a_good_replies: assert property (
      $rose(ena) && cnt_r == 4'h8 && w_r[7:3] < 5'h06 |-> ##3 $fell(d_oe_n))
      else $error("valid word got no reply in time");
   a_reply_once: assert property (nrep_r <= 2'h1)
      else $error("more than one reply in one enable phase");

   c_reply: cover property ($fell(d_oe_n));
   c_release: cover property ($rose(d_oe_n));
   c_bad_sub: cover property ($rose(ena) && cnt_r == 4'h8 && w_r[7:3] >= 5'h06);
endmodule : matrix_link_sva

/* File: tb_three_wire_serial_slave.sv */
// Testbench: host and device ends joined by one link, plus a second
// device driven directly with words of the wrong length.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/10ps
module tb_three_wire_serial_slave;
   import matrix_bus_pkg::*;
   // Host keeps its documented phase length on the link
   localparam int HC = LINK_HALF_CYC;
   localparam logic [SUB_W-1:0] CODES [N_OUT] =
      '{OUT0_CODE, OUT1_CODE, OUT2_CODE, OUT3_CODE, OUT4_CODE, OUT5_CODE};
   localparam logic [11:0] ROWS [12] = '{12'h258, 12'h008, 12'h113, 12'h0e0, 12'h2f4,
      12'h1a1, 12'h238, 12'h048, 12'h378, 12'h3c2, 12'hff8, 12'h0df};

   logic                        sys_clk, rst, rst_dev, rst2, req, busy, done;
   logic                        word_ok, word_skip, skip2, v;
   logic [WORD_LEN-1:0]         wdata, w;
   logic [3:0]                  rd_bits;
   logic [REPLY_LEN-1:0]        rdata;
   logic [15:0]                 e;
   logic [N_OUT-1:0][SEL_W-1:0] route_sel, sel2, exp_sel;
   logic [N_OUT-1:0]            route_set, set2, exp_set;
   int                          mismatches, num_checks, ok_n, skip_n, skip2_n, o0, s0, n;

   matrix_link_if link ();
   matrix_link_if link2 ();

   switch_host #(.HALF_CYC(HC)) u_switch_host (.sys_clk(sys_clk), .rst(rst),
      .bus(link.host), .req(req), .wdata(wdata), .rd_bits(rd_bits), .busy(busy),
      .done(done), .rdata(rdata));
   switch_dev u_switch_dev (.rst(rst_dev), .bus(link.dev), .route_sel(route_sel),
      .route_set(route_set), .word_ok(word_ok), .word_skip(word_skip));
   switch_dev u_switch_dev_b (.rst(rst2), .bus(link2.dev), .route_sel(sel2),
      .route_set(set2), .word_ok(), .word_skip(skip2));
   matrix_link_sva u_matrix_link_sva (.lclk(link.lclk), .rst(rst_dev), .ena(link.ena),
      .m_oe_n(link.m_oe_n), .d_dout(link.d_dout), .d_oe_n(link.d_oe_n), .data(link.data));

   // ---------------------------------------------------------------
   // Clocks, pulse counters, watchdog
   // ---------------------------------------------------------------
   // System clock, 50 ns
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Free-running link clock of the second device, 30 ns
   initial begin
      link2.lclk = 1'b0;
      forever #15 link2.lclk = ~link2.lclk;
   end
   // Count device pulses
   always @(posedge link.lclk) begin
      if (word_ok === 1'b1) ok_n++;
      if (word_skip === 1'b1) skip_n++;
   end
   always @(posedge link2.lclk) if (skip2 === 1'b1) skip2_n++;
   // Cut a hang short
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // One host request; dup holds req with another word while busy
   task automatic xfer(input logic [7:0] wd, input logic [3:0] rb, input bit dup);
      int k;
      wdata = wd;
      rd_bits = rb;
      req = 1'b1;
      @(posedge sys_clk);
      #2;
      if (dup) begin
         wdata = 8'h07;
         repeat (5) @(posedge sys_clk);
         #2;
      end
      req = 1'b0;
      for (k = 0; k < 1200 && done !== 1'b1; k++) begin
         @(posedge sys_clk);
         #2;
      end
      if (done !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
   endtask : xfer

   // Word of n bits to the second device, then an idle enable-high phase
   task automatic send2(input logic [15:0] val, input int nb);
      int i;
      @(posedge link2.lclk);
      #2;
      link2.ena = 1'b0;
      link2.m_oe_n = 1'b0;
      for (i = nb - 1; i >= 0; i--) begin
         link2.m_dout = val[i];
         @(posedge link2.lclk);
         #2;
      end
      link2.ena = 1'b1;
      link2.m_oe_n = 1'b1;
      repeat (14) @(posedge link2.lclk);
   endtask : send2

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {req, wdata, rd_bits, rst, rst_dev, rst2} = {1'b0, 8'h00, 4'h0, 3'b111};
      {link2.ena, link2.m_oe_n, link2.m_dout} = 3'b110;
      {mismatches, num_checks, ok_n, skip_n, skip2_n} = '0;
      exp_sel = '0;
      exp_set = '0;
      repeat (12) @(posedge sys_clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge link.lclk);
      #2 rst_dev = 1'b0;
      repeat (4) @(posedge link2.lclk);
      #2 rst2 = 1'b0;
      @(posedge sys_clk);
      #2;
      chk(route_set, 0);
      chk(link.d_oe_n, 1);
      chk(busy, 0);
      $display("test reset done");
      // Table of words: every output code, every input code, bad codes
      for (int r = 0; r < 12; r++) begin
         w = ROWS[r][11:4];
         n = (ROWS[r][3:0] > 4'h8) ? 8 : int'(ROWS[r][3:0]);
         o0 = ok_n;
         s0 = skip_n;
         v = 1'b0;
         for (int j = 0; j < N_OUT; j++) if (CODES[j] == w[7:3]) begin
            v = 1'b1;
            exp_sel[j] = w[2:0];
            exp_set[j] = 1'b1;
         end
         xfer(w, ROWS[r][3:0], 1'b0);
         e = v ? ({8'h00, w} >> (8 - n)) : ((16'h0001 << n) - 16'h0001);
         chk(rdata, e[7:0]);
         chk(ok_n - o0, v);
         chk(skip_n - s0, !v);
         chk(route_sel, exp_sel);
         chk(route_set, exp_set);
      end
      chk(route_set, 6'h3f);
      $display("test table done");
      // Request while busy is ignored
      o0 = ok_n;
      exp_sel[1] = 3'h1;
      xfer(8'h21, 4'h8, 1'b1);
      chk(ok_n - o0, 1);
      chk(route_sel, exp_sel);
      $display("test busy done");
      // Device reset in mid-run, then one word
      #2 rst_dev = 1'b1;
      repeat (4) @(posedge link.lclk);
      #2 rst_dev = 1'b0;
      chk(route_set, 0);
      xfer(8'h2b, 4'h8, 1'b0);
      chk(route_sel[4], 3'h3);
      chk(rdata, 8'h2b);
      $display("test rereset done");
      // Wrong lengths on the second device, then a proper word
      send2(16'h0025, 7);
      send2(16'h0025, 9);
      chk(skip2_n, 2);
      chk(set2, 0);
      send2(16'h0025, 8);
      chk(sel2[1], 3'h5);
      chk(set2, 6'h02);
      $display("test length done");
      end_of_test();
   end
endmodule : tb_three_wire_serial_slave
